// ===== pwa_i2c_master.sv
// behavioural serial bus master that drives the clock and pulls data low
`timescale 1ns/10ps
`default_nettype none
module pwa_i2c_master
(
  input wire logic sda_i, // resolved data wire
  output logic scl_o, // serial clock, idle high
  output logic sda_oe_o, // high while pulling data low
  output logic [7:0] rd_data_o, // last byte read
  output logic rd_stb_o // pulses once a byte is read
);
  localparam realtime Q = 31.25; // quarter of the 125 ns bit period
  // released bus at time zero, clock standing high
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    rd_data_o = 8'h00;
    rd_stb_o = 1'b0;
  end
  // data changes mid-low, sampled mid-high, never while the clock is high
  task automatic xbit(input logic b, output logic r);
    sda_oe_o = !b;
    #Q;
    scl_o = 1'b1;
    #Q;
    r = sda_i;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask
  // also serves as repeated start from a low clock
  task automatic start;
    sda_oe_o = 1'b0;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_oe_o = 1'b1;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask
  // clock left high afterwards so it stands still between frames
  task automatic stop;
    sda_oe_o = 1'b1;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_oe_o = 1'b0;
    #(4 * Q);
  endtask
  // msb first, ninth clock samples the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask
  // released line while the device shifts, then own ack or nack
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(!mack, r);
    rd_data_o = d;
    rd_stb_o = 1'b1;
    #1;
    rd_stb_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== pwa_i2c_regs.sv
// serial slave front end and register map of the digital potentiometer
// Overview of operation
// - device acks both ids and address, then sends data msb first
// - select register at 02h steers address 00h reads
// - select register is 8 bits, only msb matters, lower bits kept as written
// - select 00h reaches stored value, 80h reaches the wiper
// - select register is 00h after power-up
// - with select 80h, writes to 00h move only the wiper
// - at power-up the stored value is copied into the wiper
// - with select 00h, writes to 00h store the byte and move wiper
// - reading the stored value leaves the wiper untouched
// - id byte is 01010, two strap levels, then read/write bit
// - stop after a stored write starts a busy cycle ignoring the bus
// - wiper is 7 bits, 40h at power-up before the load
// - data byte lands on the scl fall of its lsb
`timescale 1ns/10ps
`default_nettype none
`include "pwa_map.svh"
module pwa_i2c_regs
  import pwa_pkg::*;
(
  input wire logic clock_i, // system clock, 200 MHz
  input wire logic rst_i, // async reset, high
  input wire logic scl_i, // serial clock pin
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // serial data drive value
  output logic sda_oe_o, // high while pulling data low
  input wire logic addr_strap_hi_i, // upper address strap
  input wire logic addr_strap_lo_i, // lower address strap
  output logic [6:0] wiper_o, // wiper tap position
  output logic nv_busy_o // store write cycle running
);
  pwa_nv_if nv ();

  pwa_nv_store u_store (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .nv(nv)
  );

  // identification byte check against family code and straps
  function automatic logic id_ok(input logic [7:0] b, input logic hi, input logic lo);
    id_ok = (b[`PWA_ID_FAMILY_MSB:`PWA_ID_FAMILY_LSB] == `PWA_ID_FAMILY) &&
            (b[`PWA_ID_STRAP_HI] == hi) && (b[`PWA_ID_STRAP_LO] == lo);
  endfunction

  // pin synchronisers; stage one feeds only stage two
  logic [1:0] scl_s1, scl_s2, scl_s3;
  logic [1:0] sync_in;
  logic [3:0] strap_s1, strap_s2;
  assign sync_in = {scl_i, sda_i};
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_s1 <= 2'h3;
      scl_s2 <= 2'h3;
      scl_s3 <= 2'h3;
      strap_s1 <= 4'h0;
      strap_s2 <= 4'h0;
    end
    else
    begin
      scl_s1 <= sync_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      strap_s1 <= {2'b00, addr_strap_hi_i, addr_strap_lo_i};
      strap_s2 <= strap_s1;
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl = scl_s2[1];
  assign sda = scl_s2[0];
  assign scl_rise = scl && !scl_s3[1];
  assign scl_fall = !scl && scl_s3[1];
  // data edges while clock stays high are frame marks
  assign start_ev = scl && scl_s3[1] && !sda && scl_s3[0];
  assign stop_ev = scl && scl_s3[1] && sda && !scl_s3[0];

  pwa_state_t state_reg, state_next;
  pwa_kind_t kind_reg, kind_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] addr_reg, addr_next;
  logic [7:0] sel_reg, sel_next;
  logic [6:0] wiper_reg, wiper_next;
  logic [7:0] nvd_reg, nvd_next;
  logic init_reg, init_next;
  logic rd_reg, rd_next;
  logic pend_reg, pend_next;
  logic mack_reg, mack_next;
  logic oe_reg, oe_next;
  logic wr_req_reg, wr_req_next;
  logic [7:0] rd_val;
  logic go, byte_done;

  // read mux: select msb picks wiper or stored value
  always_comb
  begin
    rd_val = 8'h00;
    if (addr_reg == `PWA_ADDR_WIPER)
      rd_val = sel_reg[`PWA_SEL_BIT] ? {1'b0, wiper_reg} : nv.value;
    else if (addr_reg == `PWA_ADDR_SEL)
      rd_val = sel_reg;
  end

  assign go = init_reg && !nv.busy && !start_ev && !stop_ev;
  assign byte_done = scl_fall && (cnt_reg == `PWA_BITS_PER_BYTE);

  // protocol engine and register updates
  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    addr_next = addr_reg;
    sel_next = sel_reg;
    wiper_next = wiper_reg;
    nvd_next = nvd_reg;
    init_next = init_reg;
    rd_next = rd_reg;
    pend_next = pend_reg;
    mack_next = mack_reg;
    oe_next = oe_reg;
    wr_req_next = 1'b0;
    if (!init_reg)
    begin
      // one cycle at the reset value, then the stored value loads
      wiper_next = nv.value[6:0];
      init_next = 1'b1;
    end
    else if (nv.busy)
    begin
      // write cycle: bus ignored, data line released
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end
    else if (start_ev)
    begin
      // a repeated start drops any unfinished stored write
      state_next = ST_RX;
      kind_next = K_ID;
      cnt_next = 4'h0;
      oe_next = 1'b0;
      pend_next = 1'b0;
    end
    else if (stop_ev)
    begin
      wr_req_next = pend_reg;
      pend_next = 1'b0;
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_RX:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda};
            cnt_next = cnt_reg + 4'h1;
          end
          else if (byte_done)
          begin
            cnt_next = 4'h0;
            state_next = ST_ACK;
            oe_next = 1'b1;
            case (kind_reg)
              K_ID:
              begin
                rd_next = shift_reg[`PWA_ID_RW];
                if (!id_ok(shift_reg, strap_s2[1], strap_s2[0]))
                begin
                  state_next = ST_WAIT;
                  oe_next = 1'b0;
                end
              end
              K_ADDR: addr_next = shift_reg;
              K_DATA:
              begin
                if (addr_reg == `PWA_ADDR_WIPER)
                begin
                  wiper_next = shift_reg[6:0];
                  nvd_next = shift_reg;
                  pend_next = !sel_reg[`PWA_SEL_BIT];
                end
                else if (addr_reg == `PWA_ADDR_SEL)
                  sel_next = shift_reg;
              end
              default: state_next = ST_WAIT;
            endcase
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            oe_next = 1'b0;
            if (rd_reg)
            begin
              // first data bit goes out on the fall that ends the ack
              state_next = ST_TX;
              tx_next = rd_val;
              oe_next = !rd_val[7];
              cnt_next = 4'h1;
            end
            else if (kind_reg == K_ID)
            begin
              kind_next = K_ADDR;
              state_next = ST_RX;
            end
            else if (kind_reg == K_ADDR)
            begin
              kind_next = K_DATA;
              state_next = ST_RX;
            end
            else
              state_next = ST_WAIT;
          end
        end
        ST_TX:
        begin
          if (byte_done)
          begin
            oe_next = 1'b0;
            state_next = ST_MACK;
          end
          else if (scl_fall)
          begin
            tx_next = {tx_reg[6:0], 1'b0};
            oe_next = !tx_reg[6];
            cnt_next = cnt_reg + 4'h1;
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
            mack_next = !sda;
          else if (scl_fall)
          begin
            // master ack asks for the same byte again
            if (mack_reg)
            begin
              state_next = ST_TX;
              tx_next = rd_val;
              oe_next = !rd_val[7];
              cnt_next = 4'h1;
            end
            else
              state_next = ST_WAIT;
          end
        end
        ST_IDLE, ST_WAIT: oe_next = 1'b0;
        default: state_next = ST_IDLE;
      endcase
    end
  end

  // engine registers; wiper starts centred until the load
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      kind_reg <= K_ID;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      addr_reg <= `PWA_ADDR_WIPER;
      sel_reg <= `PWA_SEL_RESET;
      wiper_reg <= `PWA_WIPER_RESET;
      nvd_reg <= 8'h00;
      init_reg <= 1'b0;
      rd_reg <= 1'b0;
      pend_reg <= 1'b0;
      mack_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_req_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      addr_reg <= addr_next;
      sel_reg <= sel_next;
      wiper_reg <= wiper_next;
      nvd_reg <= nvd_next;
      init_reg <= init_next;
      rd_reg <= rd_next;
      pend_reg <= pend_next;
      mack_reg <= mack_next;
      oe_reg <= oe_next;
      wr_req_reg <= wr_req_next;
    end
  end

  assign nv.wr_req = wr_req_reg;
  assign nv.wr_data = nvd_reg;
  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_reg;
  assign wiper_o = wiper_reg;
  assign nv_busy_o = nv.busy;

  logic dwr;
  assign dwr = go && state_reg == ST_RX && kind_reg == K_DATA && byte_done;

  property p_ack_addr;
    @(posedge clock_i) disable iff (rst_i)
    go && state_reg == ST_RX && kind_reg == K_ADDR && byte_done |=> oe_reg && state_reg == ST_ACK;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("address byte not acked");
  property p_bad_id;
    @(posedge clock_i) disable iff (rst_i)
    go && state_reg == ST_RX && kind_reg == K_ID && byte_done &&
      !id_ok(shift_reg, strap_s2[1], strap_s2[0]) |=> state_reg == ST_WAIT && !oe_reg;
  endproperty
  a_bad_id: assert property (p_bad_id) else $error("bad id byte acked");
  property p_power_up;
    @(posedge clock_i) disable iff (rst_i)
    !init_reg |-> wiper_reg == `PWA_WIPER_RESET && sel_reg == `PWA_SEL_RESET
      ##1 wiper_reg == $past(nv.value[6:0]);
  endproperty
  a_power_up: assert property (p_power_up) else $error("power-up load wrong");
  property p_vol_write;
    @(posedge clock_i) disable iff (rst_i)
    dwr && addr_reg == `PWA_ADDR_WIPER && sel_reg[`PWA_SEL_BIT] |=>
      !pend_reg && wiper_reg == $past(shift_reg[6:0]);
  endproperty
  a_vol_write: assert property (p_vol_write) else $error("wiper-only write wrong");
  property p_nv_write;
    @(posedge clock_i) disable iff (rst_i)
    dwr && addr_reg == `PWA_ADDR_WIPER && !sel_reg[`PWA_SEL_BIT] |=>
      pend_reg && nvd_reg == $past(shift_reg) && wiper_reg == $past(shift_reg[6:0]);
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("stored write wrong");
  property p_sel_write;
    @(posedge clock_i) disable iff (rst_i)
    dwr && addr_reg == `PWA_ADDR_SEL |=> sel_reg == $past(shift_reg) && $stable(wiper_reg);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write wrong");
  property p_reserved;
    @(posedge clock_i) disable iff (rst_i)
    dwr && addr_reg != `PWA_ADDR_WIPER && addr_reg != `PWA_ADDR_SEL |=>
      $stable(wiper_reg) && $stable(sel_reg) && !pend_reg;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved write had effect");
  property p_read_mux;
    @(posedge clock_i) disable iff (rst_i)
    go && state_reg == ST_ACK && rd_reg && scl_fall && addr_reg == `PWA_ADDR_WIPER |=>
      tx_reg == ($past(sel_reg[7]) ? {1'b0, $past(wiper_reg)} : $past(nv.value));
  endproperty
  a_read_mux: assert property (p_read_mux) else $error("read mux wrong");
  property p_read_keeps;
    @(posedge clock_i) disable iff (rst_i)
    state_reg == ST_TX || state_reg == ST_MACK |=> $stable(wiper_reg);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read moved wiper");
  property p_busy_quiet;
    @(posedge clock_i) disable iff (rst_i)
    stop_ev && pend_reg && init_reg && !nv.busy |=> wr_req_reg ##1 nv.busy && !oe_reg;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("stop did not start write");

  c_read: cover property (@(posedge clock_i) disable iff (rst_i) state_reg == ST_MACK);
  c_nv_write: cover property (@(posedge clock_i) disable iff (rst_i) wr_req_reg);
  c_sel_write: cover property (@(posedge clock_i) disable iff (rst_i)
    dwr && addr_reg == `PWA_ADDR_SEL);
endmodule
`default_nettype wire

// ===== pwa_i2c_regs_test.sv
// self-checking bench of the wiper block serial register path
`timescale 1ns/10ps
`default_nettype none
`include "pwa_map.svh"
module pwa_i2c_regs_test;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl;
  logic m_oe;
  logic sda;
  logic sda_o;
  logic sda_oe;
  logic [1:0] straps = 2'b10;
  logic [6:0] wiper;
  logic busy;
  logic [7:0] rd_data;
  logic rd_stb;
  logic ack;
  logic [6:0] w;
  logic [7:0] d;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int total_checks = 0;

  always #2.5 clock_i = ~clock_i;
  // open drain wire with pull-up: anyone pulling low wins
  assign sda = !m_oe & (!sda_oe | sda_o);

  pwa_i2c_regs pwa_i2c_regs_i (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_strap_hi_i(straps[1]),
    .addr_strap_lo_i(straps[0]), .wiper_o(wiper), .nv_busy_o(busy));
  pwa_i2c_master pwa_i2c_master_i (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe),
    .rd_data_o(rd_data), .rd_stb_o(rd_stb));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] idb(input logic rw);
    return {`PWA_ID_FAMILY, straps, rw};
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk1(input string what, input logic e, input logic g);
    chk8(what, {7'h00, e}, {7'h00, g});
  endtask
  // reset and straps move only at the falling edge of the system clock
  task automatic do_reset;
    @(negedge clock_i);
    rst_i = 1'b1;
    repeat (6) @(negedge clock_i);
    rst_i = 1'b0;
    repeat (6) @(negedge clock_i);
  endtask
  // bounded wait; running out shows up as a failed compare
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim)
    begin
      @(negedge clock_i);
      n++;
    end
    chk1("store busy", lvl, busy);
    // a wait that ran out ends the run here
    if (busy !== lvl)
      print_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic [6:0] ew);
    pwa_i2c_master_i.start();
    pwa_i2c_master_i.wbyte(idb(1'b0), ack);
    chk1("write id ack", 1'b1, ack);
    pwa_i2c_master_i.wbyte(a, ack);
    pwa_i2c_master_i.wbyte(dat, ack);
    chk8("wiper after data", {1'b0, ew}, {1'b0, wiper});
    chk1("data drive level", 1'b0, sda_o);
    pwa_i2c_master_i.stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] got;
    pwa_i2c_master_i.start();
    pwa_i2c_master_i.wbyte(idb(1'b0), ack);
    chk1("id ack", 1'b1, ack);
    pwa_i2c_master_i.wbyte(a, ack);
    if (a == `PWA_ADDR_WIPER || a == `PWA_ADDR_SEL)
      chk1("addr ack", 1'b1, ack);
    pwa_i2c_master_i.start();
    pwa_i2c_master_i.wbyte(idb(1'b1), ack);
    chk1("read id ack", 1'b1, ack);
    exp_q.push_back(e);
    pwa_i2c_master_i.rbyte(1'b0, got);
    pwa_i2c_master_i.stop();
  endtask

  // oldest expected byte is matched against each byte that arrives
  always @(posedge rd_stb)
  begin
    if (exp_q.size() == 0)
      chk8("unexpected read", 8'h00, 8'hxx);
    else
      chk8("read data", exp_q.pop_front(), rd_data);
  end

  initial
  begin
    #(100_000 * 5);
    miscompares++;
    $display("MISMATCH watchdog expected end seen hang");
    print_verdict();
  end

  initial
  begin
    seed = 32'h0001_5167;
    w = `PWA_WIPER_RESET;
    do_reset();
    chk8("wiper at power-up", `PWA_NV_RESET, {1'b0, wiper});
    rd(`PWA_ADDR_SEL, `PWA_SEL_RESET);
    rd(`PWA_ADDR_WIPER, `PWA_NV_RESET);
    $display("test power-up done");
    wr(`PWA_ADDR_SEL, `PWA_SEL_WIPER, w);
    rd(`PWA_ADDR_SEL, `PWA_SEL_WIPER);
    seed = xs(seed);
    d = seed[7:0];
    w = d[6:0];
    wr(`PWA_ADDR_WIPER, d, w);
    chk1("busy after wiper write", 1'b0, busy);
    rd(`PWA_ADDR_WIPER, {1'b0, w});
    $display("test volatile path done");
    wr(`PWA_ADDR_SEL, `PWA_SEL_RESET, w);
    rd(`PWA_ADDR_WIPER, `PWA_NV_RESET);
    chk8("wiper after stored read", {1'b0, w}, {1'b0, wiper});
    seed = xs(seed);
    d = seed[15:8];
    w = d[6:0];
    wr(`PWA_ADDR_WIPER, d, w);
    wait_busy(1'b1, 20);
    pwa_i2c_master_i.start();
    pwa_i2c_master_i.wbyte(idb(1'b0), ack);
    chk1("id ack while busy", 1'b0, ack);
    pwa_i2c_master_i.stop();
    wait_busy(1'b0, 1500);
    rd(`PWA_ADDR_WIPER, d);
    $display("test stored write done");
    seed = xs(seed);
    wr(`PWA_ADDR_RSVD, seed[23:16], w);
    wr(8'h03, seed[31:24], w);
    chk1("busy after reserved write", 1'b0, busy);
    rd(`PWA_ADDR_RSVD, 8'h00);
    rd(`PWA_ADDR_SEL, `PWA_SEL_RESET);
    $display("test reserved done");
    pwa_i2c_master_i.start();
    pwa_i2c_master_i.wbyte({`PWA_ID_FAMILY, ~straps, 1'b0}, ack);
    chk1("foreign id ack", 1'b0, ack);
    pwa_i2c_master_i.stop();
    @(negedge clock_i);
    straps = 2'b01;
    rd(`PWA_ADDR_SEL, `PWA_SEL_RESET);
    $display("test identity done");
    wr(`PWA_ADDR_SEL, `PWA_SEL_WIPER, w);
    // reset is power-up: the store comes back pre-programmed and reloads the wiper
    do_reset();
    chk8("wiper after reload", `PWA_NV_RESET, {1'b0, wiper});
    rd(`PWA_ADDR_SEL, `PWA_SEL_RESET);
    $display("test second reset done");
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== pwa_map.svh
// register offsets, field values, reset values and timing counts of the wiper block
`ifndef PWA_MAP_SVH
`define PWA_MAP_SVH
`define PWA_ADDR_WIPER 8'h00
`define PWA_ADDR_RSVD 8'h01
`define PWA_ADDR_SEL 8'h02
`define PWA_SEL_RESET 8'h00
`define PWA_SEL_WIPER 8'h80
`define PWA_SEL_BIT 7
`define PWA_WIPER_RESET 7'h40
`define PWA_NV_RESET 8'h40
`define PWA_ID_FAMILY 5'h0a
`define PWA_ID_FAMILY_MSB 7
`define PWA_ID_FAMILY_LSB 3
`define PWA_ID_STRAP_HI 2
`define PWA_ID_STRAP_LO 1
`define PWA_ID_RW 0
`define PWA_BITS_PER_BYTE 4'h8
`define PWA_CLK_PERIOD_NS 5
`define PWA_NVW_TIME_NS 5000
`endif

// ===== pwa_nv_if.sv
// link between the serial front end and the nonvolatile store
`timescale 1ns/10ps
`default_nettype none
interface pwa_nv_if;
  logic wr_req;
  logic [7:0] wr_data;
  logic busy;
  logic [7:0] value;
  modport store (input wr_req, input wr_data, output busy, output value);
  modport ctrl (output wr_req, output wr_data, input busy, input value);
endinterface
`default_nettype wire

// ===== pwa_nv_store.sv
// nonvolatile power-up value store with its internal write cycle timer
`timescale 1ns/10ps
`default_nettype none
`include "pwa_map.svh"
module pwa_nv_store
  import pwa_pkg::*;
(
  input wire logic clock_i, // system clock
  input wire logic rst_i, // async reset, high
  pwa_nv_if.store nv // write request and stored value
);
  // write cycle length, rounded up to whole cycles
  localparam int NVW_CYC = (`PWA_NVW_TIME_NS + `PWA_CLK_PERIOD_NS - 1) / `PWA_CLK_PERIOD_NS;
  localparam logic [15:0] NVW_CNT = 16'(NVW_CYC);
  logic [7:0] value_reg, value_next;
  logic [15:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;

  // accept a write only while idle; busy spans the whole write cycle
  always_comb
  begin
    value_next = value_reg;
    cnt_next = cnt_reg;
    if (cnt_reg != 16'h0000)
      cnt_next = cnt_reg - 16'h0001;
    else if (nv.wr_req)
    begin
      value_next = nv.wr_data;
      cnt_next = NVW_CNT;
    end
    // registered so the busy pin comes straight from a flop
    busy_next = (cnt_next != 16'h0000);
  end

  // reset stands in for power-up; the store comes up pre-programmed
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      value_reg <= `PWA_NV_RESET;
      cnt_reg <= 16'h0000;
      busy_reg <= 1'b0;
    end
    else
    begin
      value_reg <= value_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign nv.busy = busy_reg;
  assign nv.value = value_reg;

  property p_nv_take;
    @(posedge clock_i) disable iff (rst_i)
    nv.wr_req && !nv.busy |=> nv.busy && nv.value == $past(nv.wr_data);
  endproperty
  a_nv_take: assert property (p_nv_take) else $error("nv write not taken");
endmodule
`default_nettype wire

// ===== pwa_pkg.sv
// types shared by the wiper block modules
`default_nettype none
package pwa_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_WAIT} pwa_state_t;
  typedef enum logic [1:0] {K_ID, K_ADDR, K_DATA} pwa_kind_t;
endpackage
`default_nettype wire
